// *** testbench/uis_regs_sva.sv ***
`timescale 1ns/1ps
module uis_regs_chk #(
  parameter int CNT_W = 16
) (
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire uis_pkg::uis_bus_req_t bus,
  input wire logic [31:0]           rdata,
  input wire uis_pkg::uis_token_t   token,
  input wire logic                  notify_port_a,
  input wire logic                  pulldown_disable,
  input wire logic [2:0]            transceiver_config_inputs,
  input wire logic                  auto_resume_enable,
  input wire uis_pkg::uis_mark_t    rx_mark
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire ctl_wr = bus.we && bus.addr == 8'h40;
  wire msk_wr = bus.we && bus.addr == 8'h24;
  rdata_idle_a: assert property (!bus.re |=> rdata == 32'h0)
    else $error("read data outside reply");
  mark_pulse_a: assert property (token.valid |=> rx_mark.valid)
    else $error("no mark after token");
  mark_quiet_a: assert property (!token.valid |=> !rx_mark.valid)
    else $error("mark without token");
  mark_ep_a: assert property (token.valid |=> rx_mark.ep[3:0] == $past(token.ep))
    else $error("marked endpoint wrong");
  ep_read_a: assert property (token.valid ##1 !token.valid ##1 bus.re && bus.addr == 8'h30
    |=> rdata == {27'h0, 1'b1, $past(token.ep, 3)}) else $error("endpoint read wrong");
  pid_read_a: assert property (token.valid ##1 !token.valid [*3] ##1 bus.re && bus.addr == 8'h2C
    |=> rdata == {28'h0, $past(token.pid, 5)}) else $error("identifier read wrong");
  pulldown_a: assert property (ctl_wr ##1 !ctl_wr |=> pulldown_disable == $past(bus.wdata[18], 2))
    else $error("pulldown pin wrong");
  conf_pins_a: assert property (ctl_wr ##1 !ctl_wr |=> transceiver_config_inputs == $past(bus.wdata[6:4], 2))
    else $error("config pins wrong");
  resume_en_a: assert property (ctl_wr ##1 !ctl_wr |=> auto_resume_enable == $past(bus.wdata[7], 2))
    else $error("auto resume pin wrong");
  notify_off_a: assert property (msk_wr && bus.wdata[7:0] == 8'h00 ##1 !msk_wr |=> !notify_port_a)
    else $error("port a high with empty mask");
  cover property (token.valid ##1 rx_mark.valid);
  cover property (notify_port_a ##1 !notify_port_a);
  cover property (ctl_wr ##2 pulldown_disable);
endmodule : uis_regs_chk
bind uis_regs uis_regs_chk #(.CNT_W(CNT_W)) chk (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
  .token(token), .notify_port_a(notify_port_a), .pulldown_disable(pulldown_disable),
  .transceiver_config_inputs(transceiver_config_inputs), .auto_resume_enable(auto_resume_enable),
  .rx_mark(rx_mark));

// *** testbench/uis_xcvr_model.sv ***
`timescale 1ns/1ps
module uis_xcvr_model (
  input  wire logic           clk,
  output uis_pkg::uis_token_t token,
  output logic                sof_valid,
  output logic [10:0]         sof_frame,
  output logic [1:0]          linestate
);
  initial begin
    token = '0;
    sof_valid = 1'b0;
    sof_frame = 11'h000;
    linestate = uis_pkg::LS_J;
  end
  // Released fields are inverted so stale values never look valid
  task send_token(input logic [3:0] p, input logic [3:0] e);
    @(posedge clk) token <= '{1'b1, p, e};
    @(posedge clk) token <= '{1'b0, ~p, ~e};
  endtask : send_token
  task load_frame(input logic [10:0] f);
    @(posedge clk) begin
      sof_valid <= 1'b1;
      sof_frame <= f;
    end
    @(posedge clk) begin
      sof_valid <= 1'b0;
      sof_frame <= ~f;
    end
  endtask : load_frame
  task line(input logic [1:0] v);
    @(posedge clk) linestate <= v;
  endtask : line
endmodule : uis_xcvr_model

// *** testbench/usb_interface_status_regs_tb.sv ***
`timescale 1ns/1ps
module usb_interface_status_regs_tb;
  logic clk, reset_n, sof_valid, crc16_fail, rx_active, rx_error, suspended;
  logic npa, npb, npc, pdd, are, irq;
  logic [10:0] sof_frame;
  logic [1:0]  linestate, filt;
  logic [31:0] rdata;
  logic [2:0]  conf;
  uis_pkg::uis_bus_req_t bus;
  uis_pkg::uis_token_t   token;
  uis_pkg::uis_mark_t    rx_mark;
  int err_total, checks_done;
  logic [7:0]  ta [6] = '{8'h24, 8'h28, 8'h2C, 8'h34, 8'h38, 8'h3C};
  logic [31:0] te [6] = '{32'hFFFF_FFFF, 32'h0000_07FF, 32'h0000_0000, 32'h0000_FFFF, 32'hFFFF_FFFF, 32'h0000_01FF};
  uis_regs dut (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .token(token), .sof_valid(sof_valid),
    .sof_frame(sof_frame), .crc16_fail(crc16_fail), .rx_active(rx_active), .rx_error(rx_error),
    .linestate(linestate), .suspended(suspended), .linestate_filt(filt), .notify_port_a(npa),
    .notify_port_b(npb), .notify_port_c(npc), .pulldown_disable(pdd), .transceiver_config_inputs(conf),
    .auto_resume_enable(are), .rx_mark(rx_mark), .irq(irq));
  uis_xcvr_model xm (.clk(clk), .token(token), .sof_valid(sof_valid), .sof_frame(sof_frame),
    .linestate(linestate));
  task ck(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : ck
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus <= '{a, ~d, 1'b0, 1'b0};
  endtask : wr
  task rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk) bus <= '{a, 32'h0, 1'b0, 1'b0};
    #1 ck($sformatf("reg %h", a), e, rdata);
  endtask : rc
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task end_of_test;
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #100000;
    err_total++;
    end_of_test();
  end
  initial begin
    err_total = 0;
    checks_done = 0;
    reset_n = 1'b0;
    bus = '0;
    crc16_fail = 1'b0;
    rx_active = 1'b0;
    rx_error = 1'b0;
    suspended = 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 36; a <= 64; a += 4) rc(8'(a), 32'h0);
    $display("reset values done");
    foreach (ta[i]) begin
      wr(ta[i], 32'hFFFF_FFFF);
      rc(ta[i], te[i]);
    end
    wr(8'h50, 32'hFFFF_FFFF);
    rc(8'h50, 32'h0);
    $display("access kinds done");
    wr(8'h24, 32'h0002_0440);
    @(posedge clk) rx_active <= 1'b1;
    cyc(3);
    ck("port c", 1, npc);
    ck("port a", 0, npa);
    @(posedge clk) rx_active <= 1'b0;
    cyc(3);
    ck("port c", 0, npc);
    wr(8'h20, 32'h0000_0044);
    @(posedge clk) crc16_fail <= 1'b1;
    @(posedge clk) crc16_fail <= 1'b0;
    cyc(3);
    ck("port b", 1, npb);
    wr(8'h1C, 32'h0000_0004);
    cyc(2);
    ck("port b", 0, npb);
    rc(8'h1C, 32'h0000_0008);
    wr(8'h24, 32'h0001_0440);
    @(posedge clk) rx_error <= 1'b1;
    cyc(3);
    ck("port c", 1, npc);
    @(posedge clk) rx_error <= 1'b0;
    cyc(3);
    ck("port c", 0, npc);
    $display("flag routing done");
    wr(8'h34, 32'h0000_0020);
    wr(8'h48, 32'h0000_0001);
    xm.send_token(4'h9, 4'h5);
    #1 ck("mark", 6'h2B, rx_mark);
    rc(8'h30, 32'h0000_0015);
    rc(8'h2C, 32'h0000_0009);
    xm.send_token(4'h3, 4'h3);
    #1 ck("mark", 6'h07, rx_mark);
    rc(8'h30, 32'h0000_0013);
    rc(8'h2C, 32'h0000_0003);
    ck("port a", 1, npa);
    ck("irq", 1, irq);
    wr(8'h24, 32'h0002_0400);
    wr(8'h44, 32'h0000_0001);
    cyc(2);
    ck("port a", 0, npa);
    ck("irq", 0, irq);
    xm.load_frame(11'h5A3);
    rc(8'h28, 32'h0000_05A3);
    $display("tokens done");
    wr(8'h40, 32'h0004_02F0);
    rc(8'h40, 32'h0004_02F0);
    ck("pins", 5'h1F, {pdd, are, conf});
    @(posedge clk) suspended <= 1'b1;
    wr(8'h48, 32'h0000_000C);
    xm.line(uis_pkg::LS_K);
    cyc(2);
    ck("filt", uis_pkg::LS_J, filt);
    cyc(20);
    ck("filt", uis_pkg::LS_K, filt);
    rc(8'h40, 32'h0004_12F0);
    ck("irq", 1, irq);
    rc(8'h44, 32'h0000_0006);
    wr(8'h40, 32'h0004_02F0);
    wr(8'h44, 32'h0000_0004);
    rc(8'h40, 32'h0004_02F0);
    xm.line(uis_pkg::LS_SE0);
    cyc(20);
    rc(8'h40, 32'h0004_22F0);
    wr(8'h40, 32'h0004_0270);
    wr(8'h44, 32'h0000_0008);
    xm.line(uis_pkg::LS_K);
    cyc(20);
    rc(8'h40, 32'h0004_0270);
    ck("irq", 0, irq);
    $display("transceiver control done");
    end_of_test();
  end
endmodule : usb_interface_status_regs_tb

// *** verilog/uis_pkg.sv ***
// Summary of operation
// - Each notify port goes high while any flag selected by its mask byte is high.
// - Software reads and writes an 11-bit frame counter, held whole in bits 10:0 of one register.
// - Read-only 4-bit field shows the last received packet identifier, reset zero.
// - Read-only 4-bit field copies the endpoint of the last received token.
// - Endpoint valid bit is one only once a captured endpoint is valid.
// - Marked endpoints appear on the receive port ORed with 0x10.
// - Pulldown-disable bit turns off pulldowns on both USB data ports.
// - Auto-resume from SE0 sets the reset indication; software writes 0 to clear.
// - Auto-resume from K sets the resume indication; software writes 0 to clear.
// - Linestate changes propagate only after two-to-the-field clock cycles.
// - Auto-resume enable lets hardware handle resume; otherwise software polls linestate.
// - Three-bit field drives the transceiver configuration input pins directly.
// - Seven flags: token, SE0, K, J, CRC16 fail, receive active, receive error.
// - Sticky flags hold until written with one; others follow their signals.
package uis_pkg;

  localparam logic [7:0] OFS_FLAGS       = 8'h1C;
  localparam logic [7:0] OFS_HOLD_SELECT = 8'h20;
  localparam logic [7:0] OFS_PORT_MASKS  = 8'h24;
  localparam logic [7:0] OFS_FRAME       = 8'h28;
  localparam logic [7:0] OFS_PID         = 8'h2C;
  localparam logic [7:0] OFS_ENDPOINT    = 8'h30;
  localparam logic [7:0] OFS_EP_MARK     = 8'h34;
  localparam logic [7:0] OFS_OTG_MASK    = 8'h38;
  localparam logic [7:0] OFS_POWER       = 8'h3C;
  localparam logic [7:0] OFS_XCVR_CTRL   = 8'h40;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h44;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h48;

  // Transceiver control, endpoint valid and power valid field positions
  localparam int XC_CONF_LSB      = 4;
  localparam int XC_AUTO_RESUME   = 7;
  localparam int XC_FILT_LSB      = 8;
  localparam int XC_RESUME_K      = 12;
  localparam int XC_RESUME_SE0    = 13;
  localparam int XC_PULLDOWN_OFF  = 18;
  localparam int EP_VALID_BIT     = 4;
  localparam int POWER_VALID_BIT  = 8;

  // Flag bit positions
  localparam int FL_RX_ERROR  = 0;
  localparam int FL_RX_ACTIVE = 1;
  localparam int FL_CRC16     = 2;
  localparam int FL_J         = 3;
  localparam int FL_K         = 4;
  localparam int FL_SE0       = 5;
  localparam int FL_TOKEN     = 6;

  // Interrupt status bits
  localparam int IRQ_TOKEN      = 0;
  localparam int IRQ_CRC16      = 1;
  localparam int IRQ_RESUME_K   = 2;
  localparam int IRQ_RESUME_SE0 = 3;

  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_J   = 2'h1;
  localparam logic [1:0] LS_K   = 2'h2;

  localparam logic [6:0]  FLAGS_RESET = 7'h00;
  localparam logic [31:0] WORD_RESET  = 32'h0000_0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [31:0] MARK_OR     = 32'h0000_0010;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
  } uis_bus_req_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] pid;
    logic [3:0] ep;
  } uis_token_t;

  typedef struct packed {
    logic [4:0] ep;
    logic       valid;
  } uis_mark_t;

endpackage : uis_pkg

// *** verilog/uis_regs.sv ***
`timescale 1ns/1ps
module uis_regs #(
  parameter int CNT_W = 16
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire uis_pkg::uis_bus_req_t bus,
  output logic [31:0]            rdata,
  input  wire uis_pkg::uis_token_t token,
  input  wire logic              sof_valid,
  input  wire logic [10:0]       sof_frame,
  input  wire logic              crc16_fail,
  input  wire logic              rx_active,
  input  wire logic              rx_error,
  input  wire logic [1:0]        linestate,
  input  wire logic              suspended,
  output logic [1:0]             linestate_filt,
  output logic                   notify_port_a,
  output logic                   notify_port_b,
  output logic                   notify_port_c,
  output logic                   pulldown_disable,
  output logic [2:0]             transceiver_config_inputs,
  output logic                   auto_resume_enable,
  output uis_pkg::uis_mark_t     rx_mark,
  output logic                   irq
);

  typedef struct packed {
    logic [1:0]       ls_s1;
    logic [1:0]       ls_s2;
    logic [1:0]       ls_s3;
    logic [1:0]       ls_cand;
    logic [1:0]       ls_filt;
    logic [CNT_W-1:0] ls_cnt;
    logic [6:0]       flags;
    logic [6:0]       hold_sel;
    logic [31:0]      port_masks;
    logic [10:0]      frame;
    logic [3:0]       pid;
    logic [3:0]       ep;
    logic             ep_valid;
    logic [15:0]      ep_mark;
    logic [31:0]      otg_mask;
    logic [8:0]       power;
    logic             pd_off;
    logic             ind_se0;
    logic             ind_k;
    logic [3:0]       filt_log2;
    logic             auto_res;
    logic [2:0]       conf;
    logic [3:0]       irq_st;
    logic [3:0]       irq_mask;
    logic [31:0]      rdata;
    logic [2:0]       notify;
    uis_pkg::uis_mark_t mark;
    logic             irq;
  } uis_state_t;

  uis_state_t st;
  uis_state_t next_st;

  function automatic logic hit(input uis_pkg::uis_bus_req_t b, input logic [7:0] ofs);
    hit = b.we && (b.addr == ofs);
  endfunction : hit

  logic [1:0]  ls_in;
  logic [6:0]  ev;
  logic [6:0]  w1c;
  logic [CNT_W:0] cnt_inc;
  logic [CNT_W:0] cnt_lim;
  logic        ls_change;
  logic        res_se0;
  logic        res_k;
  logic [3:0]  irq_ev;
  logic [31:0] rd;

  always_comb begin
    next_st = st;
    // Third stage passed on only once the last two stages agree
    next_st.ls_s1 = linestate;
    next_st.ls_s2 = st.ls_s1;
    next_st.ls_s3 = st.ls_s2;
    ls_in = (st.ls_s2 == st.ls_s3) ? st.ls_s3 : st.ls_cand;

    cnt_inc   = {1'b0, st.ls_cnt} + {{CNT_W{1'b0}}, 1'b1};
    cnt_lim   = {{CNT_W{1'b0}}, 1'b1} << st.filt_log2;
    ls_change = 1'b0;
    if (ls_in != st.ls_cand) begin
      next_st.ls_cand = ls_in;
      next_st.ls_cnt  = uis_pkg::COUNT_RESET[CNT_W-1:0];
    end else if (st.ls_cand != st.ls_filt) begin
      if (cnt_inc >= cnt_lim) begin
        next_st.ls_filt = st.ls_cand;
        next_st.ls_cnt  = uis_pkg::COUNT_RESET[CNT_W-1:0];
        ls_change       = 1'b1;
      end else begin
        next_st.ls_cnt = cnt_inc[CNT_W-1:0];
      end
    end

    // Resume detection only when hardware owns resume
    res_se0 = ls_change && st.auto_res && suspended && (st.ls_cand == uis_pkg::LS_SE0);
    res_k   = ls_change && st.auto_res && suspended && (st.ls_cand == uis_pkg::LS_K);

    ev = '0;
    ev[uis_pkg::FL_TOKEN]     = token.valid;
    ev[uis_pkg::FL_SE0]       = st.ls_filt == uis_pkg::LS_SE0;
    ev[uis_pkg::FL_K]         = st.ls_filt == uis_pkg::LS_K;
    ev[uis_pkg::FL_J]         = st.ls_filt == uis_pkg::LS_J;
    ev[uis_pkg::FL_CRC16]     = crc16_fail;
    ev[uis_pkg::FL_RX_ACTIVE] = rx_active;
    ev[uis_pkg::FL_RX_ERROR]  = rx_error;

    w1c = hit(bus, uis_pkg::OFS_FLAGS) ? bus.wdata[6:0] : '0;
    // Sticky flags keep their value, a new event wins over the clear
    next_st.flags = (st.hold_sel & st.flags & ~w1c) | ev;

    // Ports follow the flags in the same cycle they are registered
    next_st.notify[0] = |(next_st.flags & st.port_masks[6:0]);
    next_st.notify[1] = |(next_st.flags & st.port_masks[14:8]);
    next_st.notify[2] = |(next_st.flags & st.port_masks[22:16]);

    next_st.mark.valid = 1'b0;
    if (token.valid) begin
      next_st.pid      = token.pid;
      next_st.ep       = token.ep;
      next_st.ep_valid = 1'b1;
      next_st.mark.ep  = {1'b0, token.ep} | (st.ep_mark[token.ep] ? uis_pkg::MARK_OR[4:0] : 5'h00);
      next_st.mark.valid = 1'b1;
    end

    if (sof_valid) begin
      next_st.frame = sof_frame;
    end

    if (hit(bus, uis_pkg::OFS_HOLD_SELECT)) begin
      next_st.hold_sel = bus.wdata[6:0];
    end
    if (hit(bus, uis_pkg::OFS_PORT_MASKS)) begin
      next_st.port_masks = bus.wdata;
    end
    if (hit(bus, uis_pkg::OFS_FRAME)) begin
      next_st.frame = bus.wdata[10:0];
    end
    if (hit(bus, uis_pkg::OFS_EP_MARK)) begin
      next_st.ep_mark = bus.wdata[15:0];
    end
    if (hit(bus, uis_pkg::OFS_OTG_MASK)) begin
      next_st.otg_mask = bus.wdata;
    end
    if (hit(bus, uis_pkg::OFS_POWER)) begin
      next_st.power = bus.wdata[8:0];
    end
    if (hit(bus, uis_pkg::OFS_XCVR_CTRL)) begin
      next_st.pd_off    = bus.wdata[uis_pkg::XC_PULLDOWN_OFF];
      next_st.filt_log2 = bus.wdata[uis_pkg::XC_FILT_LSB +: 4];
      next_st.auto_res  = bus.wdata[uis_pkg::XC_AUTO_RESUME];
      next_st.conf      = bus.wdata[uis_pkg::XC_CONF_LSB +: 3];
      // Writing 0 clears; writing 1 leaves the indication as it was
      next_st.ind_se0   = st.ind_se0 & bus.wdata[uis_pkg::XC_RESUME_SE0];
      next_st.ind_k     = st.ind_k & bus.wdata[uis_pkg::XC_RESUME_K];
    end
    if (res_se0) begin
      next_st.ind_se0 = 1'b1;
    end
    if (res_k) begin
      next_st.ind_k = 1'b1;
    end

    irq_ev = '0;
    irq_ev[uis_pkg::IRQ_TOKEN]      = token.valid;
    irq_ev[uis_pkg::IRQ_CRC16]      = crc16_fail;
    irq_ev[uis_pkg::IRQ_RESUME_K]   = res_k;
    irq_ev[uis_pkg::IRQ_RESUME_SE0] = res_se0;
    next_st.irq_st = (st.irq_st & ~(hit(bus, uis_pkg::OFS_IRQ_STATUS) ? bus.wdata[3:0] : 4'h0)) | irq_ev;
    if (hit(bus, uis_pkg::OFS_IRQ_MASK)) begin
      next_st.irq_mask = bus.wdata[3:0];
    end
    next_st.irq = |(next_st.irq_st & next_st.irq_mask);

    rd = '0;
    case (bus.addr)
      uis_pkg::OFS_FLAGS:       rd[6:0]  = st.flags;
      uis_pkg::OFS_HOLD_SELECT: rd[6:0]  = st.hold_sel;
      uis_pkg::OFS_PORT_MASKS:  rd       = st.port_masks;
      uis_pkg::OFS_FRAME:       rd[10:0] = st.frame;
      uis_pkg::OFS_PID:         rd[3:0]  = st.pid;
      uis_pkg::OFS_ENDPOINT:    rd[4:0]  = {st.ep_valid, st.ep};
      uis_pkg::OFS_EP_MARK:     rd[15:0] = st.ep_mark;
      uis_pkg::OFS_OTG_MASK:    rd       = st.otg_mask;
      uis_pkg::OFS_POWER:       rd[8:0]  = st.power;
      uis_pkg::OFS_XCVR_CTRL: begin
        rd[uis_pkg::XC_PULLDOWN_OFF]      = st.pd_off;
        rd[uis_pkg::XC_RESUME_SE0]        = st.ind_se0;
        rd[uis_pkg::XC_RESUME_K]          = st.ind_k;
        rd[uis_pkg::XC_FILT_LSB +: 4]     = st.filt_log2;
        rd[uis_pkg::XC_AUTO_RESUME]       = st.auto_res;
        rd[uis_pkg::XC_CONF_LSB +: 3]     = st.conf;
      end
      uis_pkg::OFS_IRQ_STATUS:  rd[3:0]  = st.irq_st;
      uis_pkg::OFS_IRQ_MASK:    rd[3:0]  = st.irq_mask;
      default:                  rd       = '0;
    endcase
    // Read data stands only in the cycle after the strobe
    next_st.rdata = bus.re ? rd : uis_pkg::WORD_RESET;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata                     = st.rdata;
  assign linestate_filt            = st.ls_filt;
  assign notify_port_a             = st.notify[0];
  assign notify_port_b             = st.notify[1];
  assign notify_port_c             = st.notify[2];
  assign pulldown_disable          = st.pd_off;
  assign transceiver_config_inputs = st.conf;
  assign auto_resume_enable        = st.auto_res;
  assign rx_mark                   = st.mark;
  assign irq                       = st.irq;

endmodule : uis_regs
